// [design/udil_pkg.sv]
package udil_pkg;

	// Command code and transfer length of the status word read
	localparam logic [7:0]  CMD_READ_STATUS    = 8'hC0;
	localparam int          STATUS_BYTES       = 4;

	// Status word field positions
	localparam int          BIT_BUS_RESET      = 0;
	localparam int          BIT_RESUME         = 1;
	localparam int          BIT_SUSPEND_CHANGE = 2;
	localparam int          BIT_TRANSFER_END   = 3;
	localparam int          BIT_FRAME_START    = 4;
	localparam int          BIT_PSEUDO_FRAME   = 5;
	localparam int          BIT_SHORT_END      = 6;
	localparam int          BIT_LIVE_SUSPENDED = 7;
	localparam int          BIT_CONTROL_OUT    = 8;
	localparam int          BIT_CONTROL_IN     = 9;
	localparam int          BIT_EP_FIRST       = 8;
	localparam int          EP_EVENTS          = 16;
	localparam int          BIT_RESERVED_LSB   = 24;

	// Reset value and bit groups of the status word
	localparam logic [31:0] STATUS_RESET       = 32'h00000000;
	localparam logic [31:0] CLEAR_ON_READ_MASK = 32'h0000007F;
	localparam logic [31:0] EVENT_MASK         = 32'h00FFFF7F;

	// Interrupt output idle level after reset: active low, so idle high
	localparam logic        IRQ_OUT_RESET      = 1'b1;

	// Timing
	localparam int          CLK_PERIOD_NS      = 10;
	localparam int          FRAME_PERIOD_NS    = 1000000;
	localparam int          FRAME_CYCLES       = FRAME_PERIOD_NS / CLK_PERIOD_NS;
	localparam int          PULSE_NS           = 166;
	localparam int          PULSE_CYCLES       = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          PULSE_CW           = $clog2(PULSE_CYCLES + 1);
	localparam int          MISSED_FRAME_LIMIT = 3;

	// Status read sequencer, Gray coded along the byte path
	typedef enum logic [2:0] {
		RD_IDLE  = 3'h0,
		RD_BYTE0 = 3'h1,
		RD_BYTE1 = 3'h3,
		RD_BYTE2 = 3'h2,
		RD_BYTE3 = 3'h6
	} udil_rd_state_t;

endpackage

// [design/udil_frame_if.sv]
`timescale 1ns/10ps
interface udil_frame_if;
	logic sof;
	logic bus_reset;
	logic resume;
	logic tick;
	logic suspended;

	modport timer (input sof, input bus_reset, input resume, output tick, output suspended);
	modport owner (output sof, output bus_reset, output resume, input tick, input suspended);
endinterface

// [design/udil_frame_timer.sv]
`timescale 1ns/10ps
module udil_frame_timer #(
	parameter int FRAME_CYCLES = udil_pkg::FRAME_CYCLES
) (
	input  wire logic   clock_i,  // System clock
	input  wire logic   reset_i,  // Synchronous reset, active high
	udil_frame_if.timer fr        // Frame events in, tick and suspend out
);
	localparam int CW = $clog2(FRAME_CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(FRAME_CYCLES - 1);
	localparam logic [1:0]    LIMIT = 2'(udil_pkg::MISSED_FRAME_LIMIT);

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic [1:0]    missed;
		logic          suspended;
		logic          tick;
	} udil_ft_state_t;

	udil_ft_state_t state_reg;
	udil_ft_state_t state_next;

	always_comb begin
		state_next = state_reg;
		state_next.tick = 1'b0;
		if (fr.sof || fr.bus_reset || fr.resume) begin
			state_next.cnt = '0;
			state_next.missed = '0;
			state_next.suspended = 1'b0;
		end else if (!state_reg.suspended) begin
			if (state_reg.cnt == LAST) begin
				// Frame expected but none seen
				state_next.cnt = '0;
				state_next.tick = 1'b1;
				state_next.missed = state_reg.missed + 2'h1;
				if (state_reg.missed + 2'h1 == LIMIT) begin
					state_next.suspended = 1'b1;
				end
			end else begin
				state_next.cnt = state_reg.cnt + CW'(1);
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign fr.tick = state_reg.tick;
	assign fr.suspended = state_reg.suspended;

	property p_tick_on_wrap;
		@(posedge clock_i) disable iff (reset_i)
		(state_reg.cnt == LAST && !state_reg.suspended && !fr.sof && !fr.bus_reset
			&& !fr.resume) |=> fr.tick;
	endproperty
	a_tick_on_wrap: assert property (p_tick_on_wrap) else $error("missed frame gave no tick");

	property p_suspend_after_limit;
		@(posedge clock_i) disable iff (reset_i)
		(fr.tick && state_reg.missed == LIMIT) |-> fr.suspended;
	endproperty
	a_suspend_after_limit: assert property (p_suspend_after_limit) else $error("no suspend");

	c_suspend: cover property (@(posedge clock_i) disable iff (reset_i) $rose(fr.suspended));
endmodule

// [design/udil_irq_top.sv]
`timescale 1ns/10ps
module udil_irq_top #(
	parameter int FRAME_CYCLES = udil_pkg::FRAME_CYCLES
) (
	input  wire logic        clock_i,                 // System clock
	input  wire logic        reset_i,                 // Synchronous reset, active high
	input  wire logic        cmd_strobe_i,            // Command byte valid, one cycle
	input  wire logic [7:0]  cmd_code_i,              // Command code
	input  wire logic        rd_strobe_i,             // Data byte consumed, one cycle
	output logic      [7:0]  rd_data_o,               // Current status byte
	output logic             rd_active_o,             // Status transfer in progress
	input  wire logic        sof_i,                   // Frame start packet seen
	input  wire logic        bus_reset_i,             // Bus reset detected
	input  wire logic        resume_i,                // Resume detected
	input  wire logic        bus_suspended_i,         // Bus idle long enough to suspend
	input  wire logic        dma_count_zero_i,        // DMA counter reached zero
	input  wire logic        short_packet_transfer_end_i, // Transfer ended by short packet
	input  wire logic [15:0] ep_ack_sent_i,           // ACK sent for OUT or SETUP data
	input  wire logic [15:0] ep_ack_rcvd_i,           // ACK received for IN data
	input  wire logic [15:0] ep_iso_done_i,           // Isochronous packet done
	input  wire logic [15:0] ep_status_read_i,        // Endpoint status register read
	input  wire logic [31:0] irq_enable_i,            // Per-source interrupt enables
	input  wire logic        global_irq_enable_i,     // Global interrupt enable
	input  wire logic        irq_polarity_select_i,   // 1: active high, 0: active low
	input  wire logic        irq_signalling_select_i, // 1: pulse, 0: level
	output logic             irq_o,                   // Interrupt output
	output logic             live_bus_suspended_o,    // Registered live suspend state
	output logic             suspend_enter_o          // Suspended after missed frames
);
	typedef struct packed {
		logic [31:0]                     status;
		logic [31:0]                     snap;
		udil_pkg::udil_rd_state_t        rd_state;
		logic                            rd_active;
		logic [7:0]                      rd_data;
		logic                            live;
		logic                            irq_prev;
		logic [udil_pkg::PULSE_CW-1:0]   pulse_cnt;
		logic                            irq_out;
	} udil_top_state_t;

	localparam logic [udil_pkg::PULSE_CW-1:0] PULSE_LOAD =
		udil_pkg::PULSE_CW'(udil_pkg::PULSE_CYCLES);

	udil_top_state_t state_reg;
	udil_top_state_t state_next;
	udil_frame_if    fi ();

	logic        live_now;
	logic        take_read;
	logic [31:0] events;
	logic [31:0] clears;
	logic [31:0] snap_now;
	logic        irq_active;
	logic        irq_asserted;

	assign fi.sof = sof_i;
	assign fi.bus_reset = bus_reset_i;
	assign fi.resume = resume_i;

	udil_frame_timer #(
		.FRAME_CYCLES (FRAME_CYCLES)
	) u_frame_timer (
		.clock_i (clock_i),
		.reset_i (reset_i),
		.fr      (fi)
	);

	always_comb begin
		// Bus side suspend or our own after missed frames
		live_now = bus_suspended_i | fi.suspended;
		take_read = cmd_strobe_i && (cmd_code_i == udil_pkg::CMD_READ_STATUS);

		events = '0;
		events[udil_pkg::BIT_BUS_RESET] = bus_reset_i;
		events[udil_pkg::BIT_RESUME] = resume_i;
		events[udil_pkg::BIT_SUSPEND_CHANGE] = live_now & ~state_reg.live;
		events[udil_pkg::BIT_TRANSFER_END] = dma_count_zero_i;
		events[udil_pkg::BIT_FRAME_START] = sof_i;
		events[udil_pkg::BIT_PSEUDO_FRAME] = fi.tick;
		events[udil_pkg::BIT_SHORT_END] = short_packet_transfer_end_i;
		// Producers raise ack_sent only after our ACK went out
		events[udil_pkg::BIT_EP_FIRST +: udil_pkg::EP_EVENTS] =
			ep_ack_sent_i | ep_ack_rcvd_i | ep_iso_done_i;

		clears = '0;
		if (take_read) begin
			clears = udil_pkg::CLEAR_ON_READ_MASK;
		end
		clears[udil_pkg::BIT_EP_FIRST +: udil_pkg::EP_EVENTS] = ep_status_read_i;

		snap_now = state_reg.status;
		snap_now[udil_pkg::BIT_LIVE_SUSPENDED] = live_now;

		state_next = state_reg;
		// Set beats clear, so an event in the read cycle shows next read
		state_next.status = ((state_reg.status & ~clears) | events)
			& udil_pkg::EVENT_MASK;
		state_next.live = live_now;

		// Status read sequencer, lower byte first
		case (state_reg.rd_state)
			udil_pkg::RD_IDLE: begin
				state_next.rd_data = 8'h00;
			end
			udil_pkg::RD_BYTE0: begin
				if (rd_strobe_i) begin
					state_next.rd_state = udil_pkg::RD_BYTE1;
					state_next.rd_data = state_reg.snap[15:8];
				end
			end
			udil_pkg::RD_BYTE1: begin
				if (rd_strobe_i) begin
					state_next.rd_state = udil_pkg::RD_BYTE2;
					state_next.rd_data = state_reg.snap[23:16];
				end
			end
			udil_pkg::RD_BYTE2: begin
				if (rd_strobe_i) begin
					state_next.rd_state = udil_pkg::RD_BYTE3;
					state_next.rd_data = state_reg.snap[31:24];
				end
			end
			udil_pkg::RD_BYTE3: begin
				if (rd_strobe_i) begin
					state_next.rd_state = udil_pkg::RD_IDLE;
					state_next.rd_data = 8'h00;
				end
			end
			default: begin
				state_next.rd_state = udil_pkg::RD_IDLE;
				state_next.rd_data = 8'h00;
			end
		endcase
		// Any new command abandons an unfinished read
		if (cmd_strobe_i) begin
			state_next.rd_state = udil_pkg::RD_IDLE;
			state_next.rd_data = 8'h00;
		end
		if (take_read) begin
			state_next.snap = snap_now;
			state_next.rd_state = udil_pkg::RD_BYTE0;
			state_next.rd_data = snap_now[7:0];
		end
		state_next.rd_active = (state_next.rd_state != udil_pkg::RD_IDLE);

		// Pseudo tick is gated by its own bit in the enable word
		irq_active = global_irq_enable_i
			&& |(state_reg.status & irq_enable_i & udil_pkg::EVENT_MASK);
		state_next.irq_prev = irq_active;
		if (irq_active && !state_reg.irq_prev) begin
			state_next.pulse_cnt = PULSE_LOAD;
		end else if (state_reg.pulse_cnt != '0) begin
			state_next.pulse_cnt = state_reg.pulse_cnt - udil_pkg::PULSE_CW'(1);
		end
		// Pulse already started runs to length even if masked meanwhile
		irq_asserted = irq_signalling_select_i ? (state_next.pulse_cnt != '0)
			: irq_active;
		state_next.irq_out = irq_polarity_select_i ? irq_asserted : ~irq_asserted;
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			state_reg.status <= udil_pkg::STATUS_RESET;
			state_reg.snap <= udil_pkg::STATUS_RESET;
			state_reg.rd_state <= udil_pkg::RD_IDLE;
			state_reg.rd_active <= 1'b0;
			state_reg.rd_data <= 8'h00;
			state_reg.live <= 1'b0;
			state_reg.irq_prev <= 1'b0;
			state_reg.pulse_cnt <= '0;
			state_reg.irq_out <= udil_pkg::IRQ_OUT_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	assign rd_data_o = state_reg.rd_data;
	assign rd_active_o = state_reg.rd_active;
	assign irq_o = state_reg.irq_out;
	assign live_bus_suspended_o = state_reg.live;
	assign suspend_enter_o = fi.suspended;

	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (reset_i);

	property p_read_first_byte;
		take_read |=> rd_active_o && rd_data_o == $past(snap_now[7:0]);
	endproperty
	a_read_first_byte: assert property (p_read_first_byte) else $error("byte 0 wrong");

	property p_four_bytes;
		(take_read ##1 (rd_strobe_i && !cmd_strobe_i) [*3]) |=>
			rd_active_o && rd_data_o == 8'h00 && state_reg.rd_state == udil_pkg::RD_BYTE3;
	endproperty
	a_four_bytes: assert property (p_four_bytes) else $error("fourth byte not reached");

	property p_reserved_zero;
		state_reg.status[31:24] == 8'h00 && state_reg.status[udil_pkg::BIT_LIVE_SUSPENDED] == 1'b0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

	property p_live_in_snapshot;
		take_read |=> state_reg.snap[udil_pkg::BIT_LIVE_SUSPENDED] == $past(live_now);
	endproperty
	a_live_in_snapshot: assert property (p_live_in_snapshot) else $error("live bit stale");

	property p_frame_logged;
		sof_i |=> state_reg.status[udil_pkg::BIT_FRAME_START];
	endproperty
	a_frame_logged: assert property (p_frame_logged) else $error("frame start lost");

	property p_clear_on_read;
		(take_read && !bus_reset_i) |=> !state_reg.status[udil_pkg::BIT_BUS_RESET];
	endproperty
	a_clear_on_read: assert property (p_clear_on_read) else $error("reset bit kept");

	property p_ep_survives_read;
		(take_read && state_reg.status[udil_pkg::BIT_CONTROL_OUT] && !ep_status_read_i[0])
			|=> state_reg.status[udil_pkg::BIT_CONTROL_OUT];
	endproperty
	a_ep_survives_read: assert property (p_ep_survives_read) else $error("ep bit lost");

	property p_suspend_change;
		(live_now && !state_reg.live) |=> state_reg.status[udil_pkg::BIT_SUSPEND_CHANGE];
	endproperty
	a_suspend_change: assert property (p_suspend_change) else $error("no change flag");

	property p_global_mask;
		(!global_irq_enable_i && state_next.pulse_cnt == '0)
			|=> irq_o == !$past(irq_polarity_select_i);
	endproperty
	a_global_mask: assert property (p_global_mask) else $error("masked irq active");

	property p_level_mode;
		(!irq_signalling_select_i && irq_active) |=> irq_o == $past(irq_polarity_select_i);
	endproperty
	a_level_mode: assert property (p_level_mode) else $error("level irq missing");

	property p_pulse_length;
		(irq_signalling_select_i && irq_active && !state_reg.irq_prev) |=>
			state_reg.pulse_cnt == PULSE_LOAD ##16 state_reg.pulse_cnt == 5'h01
			##1 (state_reg.pulse_cnt == '0 || state_reg.pulse_cnt == PULSE_LOAD);
	endproperty
	a_pulse_length: assert property (p_pulse_length) else $error("pulse length wrong");

	property p_pseudo_enable;
		(state_reg.status == 32'h00000020 && !irq_enable_i[udil_pkg::BIT_PSEUDO_FRAME])
			|-> !irq_active;
	endproperty
	a_pseudo_enable: assert property (p_pseudo_enable) else $error("pseudo irq ungated");

	property p_short_end_logged;
		short_packet_transfer_end_i |=> state_reg.status[udil_pkg::BIT_SHORT_END];
	endproperty
	a_short_end_logged: assert property (p_short_end_logged) else $error("short end lost");

	property p_transfer_end_logged;
		dma_count_zero_i |=> state_reg.status[udil_pkg::BIT_TRANSFER_END];
	endproperty
	a_transfer_end_logged: assert property (p_transfer_end_logged) else $error("end lost");

	property p_bus_reset_logged;
		bus_reset_i |=> state_reg.status[udil_pkg::BIT_BUS_RESET];
	endproperty
	a_bus_reset_logged: assert property (p_bus_reset_logged) else $error("reset lost");

	property p_resume_logged;
		resume_i |=> state_reg.status[udil_pkg::BIT_RESUME];
	endproperty
	a_resume_logged: assert property (p_resume_logged) else $error("resume lost");

	property p_pseudo_logged;
		fi.tick |=> state_reg.status[udil_pkg::BIT_PSEUDO_FRAME];
	endproperty
	a_pseudo_logged: assert property (p_pseudo_logged) else $error("pseudo tick lost");

	property p_ack_logged;
		(ep_ack_sent_i | ep_ack_rcvd_i) != 16'h0000 |=>
			(state_reg.status[23:8] & $past(ep_ack_sent_i)) == $past(ep_ack_sent_i)
			&& (state_reg.status[23:8] & $past(ep_ack_rcvd_i)) == $past(ep_ack_rcvd_i);
	endproperty
	a_ack_logged: assert property (p_ack_logged) else $error("ack event lost");

	property p_iso_logged;
		ep_iso_done_i != 16'h0000 |=>
			(state_reg.status[23:8] & $past(ep_iso_done_i)) == $past(ep_iso_done_i);
	endproperty
	a_iso_logged: assert property (p_iso_logged) else $error("iso event lost");

	property p_ep_cleared;
		(ep_status_read_i[0] && !ep_ack_sent_i[0] && !ep_ack_rcvd_i[0] && !ep_iso_done_i[0])
			|=> !state_reg.status[udil_pkg::BIT_CONTROL_OUT];
	endproperty
	a_ep_cleared: assert property (p_ep_cleared) else $error("ep bit not cleared");

	property p_pseudo_cleared;
		(take_read && !fi.tick) |=> !state_reg.status[udil_pkg::BIT_PSEUDO_FRAME];
	endproperty
	a_pseudo_cleared: assert property (p_pseudo_cleared) else $error("pseudo bit kept");

	property p_change_cleared;
		(take_read && !(live_now && !state_reg.live))
			|=> !state_reg.status[udil_pkg::BIT_SUSPEND_CHANGE];
	endproperty
	a_change_cleared: assert property (p_change_cleared) else $error("change bit kept");

	property p_pulse_idle;
		(irq_signalling_select_i && state_next.pulse_cnt == '0)
			|=> irq_o == !$past(irq_polarity_select_i);
	endproperty
	a_pulse_idle: assert property (p_pulse_idle) else $error("pulse irq stuck");

	property p_second_byte;
		(state_reg.rd_state == udil_pkg::RD_BYTE0 && rd_strobe_i && !cmd_strobe_i)
			|=> rd_data_o == $past(state_reg.snap[15:8]);
	endproperty
	a_second_byte: assert property (p_second_byte) else $error("byte 1 wrong");

	c_full_read: cover property (take_read ##1 rd_strobe_i [*4]);
	c_pulse: cover property (irq_signalling_select_i && $rose(irq_active));
	c_event_during_read: cover property (take_read && sof_i);
endmodule

// [tb/udil_host_model.sv]
`timescale 1ns/10ps
module udil_host_model (
	input  wire logic       clock_i,      // System clock
	input  wire logic [7:0] rd_data_i,    // Status byte from the device
	input  wire logic       rd_active_i,  // Status transfer in progress
	output logic            cmd_strobe_o, // Command byte valid
	output logic      [7:0] cmd_code_o,   // Command code
	output logic            rd_strobe_o   // Data byte consumed
);
	initial begin
		cmd_strobe_o = 1'b0;
		cmd_code_o   = 8'h00;
		rd_strobe_o  = 1'b0;
	end

	// Always the whole word; a short read would leave the sequencer mid-transfer
	task automatic read_status(output logic [31:0] word, output logic ok);
		int n;
		ok   = 1'b0;
		word = 32'h00000000;
		@(negedge clock_i);
		cmd_code_o   = udil_pkg::CMD_READ_STATUS;
		cmd_strobe_o = 1'b1;
		@(negedge clock_i);
		cmd_strobe_o = 1'b0;
		// Code bus is not held at the last value once released
		cmd_code_o   = ~udil_pkg::CMD_READ_STATUS;
		for (n = 0; n < 8 && rd_active_i !== 1'b1; n++) begin
			@(negedge clock_i);
		end
		if (rd_active_i !== 1'b1) begin
			return;
		end
		for (n = 0; n < udil_pkg::STATUS_BYTES; n++) begin
			word[8*n +: 8] = rd_data_i;
			rd_strobe_o    = 1'b1;
			@(negedge clock_i);
		end
		rd_strobe_o = 1'b0;
		ok          = 1'b1;
	endtask
endmodule

// [tb/test_usb_device_interrupt_logic.sv]
`timescale 1ns/10ps
module test_usb_device_interrupt_logic;
	localparam int          FC    = 200;
	localparam logic [31:0] SCOPE = 32'hFFFFFF5B;
	localparam logic [31:0] EPM   = 32'hFFFFFF00;

	logic        clock_i = 1'b0;
	logic        reset_i = 1'b1;
	logic        cmd_strobe, rd_strobe, rd_active, irq, live, susp, ok;
	logic [7:0]  cmd_code, rd_data;
	logic        sof_i, bus_reset_i, resume_i, bus_suspended_i, dma_i, short_i;
	logic [15:0] ack_sent, ack_rcvd, iso_done, ep_read, e, r;
	logic [31:0] irq_en, w, src, seed;
	logic        glob, pol, sig;
	logic [4:0]  m;
	int          num_errors = 0;
	int          cmp_count = 0;
	int          cycles = 0;
	int          i, n;

	always #5 clock_i = ~clock_i;

	udil_host_model host (.clock_i(clock_i), .rd_data_i(rd_data), .rd_active_i(rd_active),
		.cmd_strobe_o(cmd_strobe), .cmd_code_o(cmd_code), .rd_strobe_o(rd_strobe));

	udil_irq_top #(.FRAME_CYCLES(FC)) uut (.clock_i(clock_i), .reset_i(reset_i),
		.cmd_strobe_i(cmd_strobe), .cmd_code_i(cmd_code), .rd_strobe_i(rd_strobe),
		.rd_data_o(rd_data), .rd_active_o(rd_active), .sof_i(sof_i),
		.bus_reset_i(bus_reset_i), .resume_i(resume_i), .bus_suspended_i(bus_suspended_i),
		.dma_count_zero_i(dma_i), .short_packet_transfer_end_i(short_i),
		.ep_ack_sent_i(ack_sent), .ep_ack_rcvd_i(ack_rcvd), .ep_iso_done_i(iso_done),
		.ep_status_read_i(ep_read),
		.irq_enable_i(irq_en), .global_irq_enable_i(glob), .irq_polarity_select_i(pol),
		.irq_signalling_select_i(sig), .irq_o(irq), .live_bus_suspended_o(live),
		.suspend_enter_o(susp));

	task automatic end_sim();
		$display("errors %0d comparisons %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	always @(posedge clock_i) begin
		cycles++;
		// Whole run needs well under this; a hang ends here
		if (cycles == 5000) begin
			num_errors++;
			end_sim();
		end
	end

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic rd();
		host.read_status(w, ok);
		check("transfer_done", 32'h1, {31'h0, ok});
	endtask

	task automatic pulse_bus(input logic [4:0] v);
		@(negedge clock_i);
		{sof_i, short_i, dma_i, resume_i, bus_reset_i} = v;
		@(negedge clock_i);
		{sof_i, short_i, dma_i, resume_i, bus_reset_i} = 5'h00;
	endtask

	task automatic wait_n(input int k);
		repeat (k) @(negedge clock_i);
	endtask

	function automatic logic [31:0] exp_bus(input logic [4:0] v);
		exp_bus = 32'h00000000;
		exp_bus[udil_pkg::BIT_BUS_RESET]    = v[0];
		exp_bus[udil_pkg::BIT_RESUME]       = v[1];
		exp_bus[udil_pkg::BIT_TRANSFER_END] = v[2];
		exp_bus[udil_pkg::BIT_SHORT_END]    = v[3];
		exp_bus[udil_pkg::BIT_FRAME_START]  = v[4];
	endfunction

	initial begin
		{sof_i, short_i, dma_i, resume_i, bus_reset_i, bus_suspended_i} = 6'h00;
		{ack_sent, ack_rcvd, iso_done, ep_read} = 64'h0;
		{irq_en, glob, pol, sig} = 35'h0;
		seed = $urandom(32'h3eead304);
		wait_n(16);
		reset_i = 1'b0;
		check("irq_reset", 32'h1, {31'h0, irq});
		rd();
		check("status_reset", udil_pkg::STATUS_RESET, w);
		for (i = 0; i < 4; i++) begin
			m = (i == 0) ? 5'h1F : 5'($urandom());
			pulse_bus(m);
			rd();
			check("bus_events", exp_bus(m), w & SCOPE);
			rd();
			check("bus_cleared", 32'h0, w & SCOPE);
		end
		for (i = 0; i < 3; i++) begin
			e   = (i == 0) ? 16'hFFFF : 16'($urandom());
			r   = 16'($urandom());
			src = $urandom();
			@(negedge clock_i);
			ack_sent = e & src[15:0];
			ack_rcvd = e & ~src[15:0] & src[31:16];
			iso_done = e & ~src[15:0] & ~src[31:16];
			@(negedge clock_i);
			{ack_sent, ack_rcvd, iso_done} = 48'h0;
			rd();
			check("ep_events", {8'h00, e, 8'h00}, w & EPM);
			rd();
			check("ep_kept", {8'h00, e, 8'h00}, w & EPM);
			@(negedge clock_i);
			ep_read = r;
			@(negedge clock_i);
			ep_read = 16'h0;
			rd();
			check("ep_cleared", {8'h00, e & ~r, 8'h00}, w & EPM);
			// Leftover endpoint bits would spoil the next round's expectation
			@(negedge clock_i);
			ep_read = 16'hFFFF;
			@(negedge clock_i);
			ep_read = 16'h0;
		end
		irq_en = 32'h1;
		glob   = 1'b1;
		pulse_bus(5'h02);
		wait_n(3);
		check("irq_unenabled", 32'h1, {31'h0, irq});
		pulse_bus(5'h01);
		wait_n(3);
		check("irq_level_low", 32'h0, {31'h0, irq});
		glob = 1'b0;
		wait_n(3);
		check("irq_global_off", 32'h1, {31'h0, irq});
		glob = 1'b1;
		pol  = 1'b1;
		wait_n(3);
		check("irq_level_high", 32'h1, {31'h0, irq});
		rd();
		wait_n(3);
		check("irq_released", 32'h0, {31'h0, irq});
		sig    = 1'b1;
		irq_en = 32'h10;
		wait_n(3);
		pulse_bus(5'h10);
		n = 0;
		repeat (40) begin
			@(negedge clock_i);
			n += (irq === 1'b1);
		end
		check("pulse_cycles", 32'(udil_pkg::PULSE_CYCLES), 32'(n));
		{sig, pol} = 2'b00;
		irq_en = 32'h20;
		pulse_bus(5'h10);
		rd();
		check("irq_idle", 32'h1, {31'h0, irq});
		wait_n(FC);
		check("irq_tick", 32'h0, {31'h0, irq});
		rd();
		check("tick_bit", 32'h20, w & 32'hA4);
		wait_n(2 * FC - 40);
		check("no_suspend_yet", 32'h0, {31'h0, susp});
		wait_n(40);
		check("suspend_entered", 32'h1, {31'h0, susp});
		check("live_out", 32'h1, {31'h0, live});
		rd();
		check("suspend_bits", 32'h84, w & 32'h84);
		rd();
		check("suspend_cleared", 32'h80, w & 32'hA4);
		pulse_bus(5'h02);
		wait_n(3);
		check("suspend_left", 32'h0, {31'h0, susp});
		rd();
		check("awake_bits", 32'h02, w & 32'h82);
		bus_suspended_i = 1'b1;
		wait_n(3);
		rd();
		check("bus_suspend", 32'h84, w & 32'h84);
		bus_suspended_i = 1'b0;
		wait_n(3);
		rd();
		check("bus_awake", 32'h00, w & 32'h84);
		irq_en = 32'h30;
		pulse_bus(5'h10);
		wait_n(3);
		check("irq_frame_only", 32'h0, {31'h0, irq});
		end_sim();
	end
endmodule
